// ==== hw/mem_clk_cfg_map.vh ====
// Purpose: offsets, fields, reset values and timing for the memory clock
//          configuration register block.
// Assumes: 32-bit register port, 50 MHz system clock.
// Notes:   header of definitions only.
`ifndef MEM_CLK_CFG_MAP_VH
`define MEM_CLK_CFG_MAP_VH

// register offsets
`define CFG_OFFSET           8'h00
`define CTRL_OFFSET          8'h04

// field positions in the configuration word
`define F_PLL_READY          31
`define F_PLL_DISABLE        30
`define F_DIV2_HI            29
`define F_DIV2_LO            27
`define F_DIV1_HI            26
`define F_DIV1_LO            24
`define F_REG_READY          23
`define F_REG_DISABLE        22
`define F_MULT_HI            15
`define F_MULT_LO            8
`define F_VREF_HI            7
`define F_VREF_LO            6
`define F_IDIV_HI            5
`define F_IDIV_LO            0

// reset values
`define RST_DIV              3'h7
`define RST_MULT             8'hFF
`define RST_VREF             2'h3
`define RST_IDIV             6'h3F

// timing: lock time in us, regulator settle in us, 20 ns clock
`define CLK_PERIOD_NS        20
`define LOCK_TIME_US         100
`define LOCK_CYCLES          ((`LOCK_TIME_US * 1000) / `CLK_PERIOD_NS)
`define VREG_TIME_US         10
`define VREG_CYCLES          ((`VREG_TIME_US * 1000) / `CLK_PERIOD_NS)

`endif

// ==== hw/mem_clk_divider.v ====
// Purpose: divide a clock-enable tick stream by a 3-bit code (1..7).
// Assumes: code 0 is reserved; treated as hold (no output ticks).
// Notes:   one output tick per div_i input ticks.
`timescale 1ns/100ps
module mem_clk_divider (
  // clock and reset
  input  wire       clk_sys_i,
  input  wire       rst_i,
  // tick in, divider code, tick out
  input  wire       tick_i,
  input  wire [2:0] div_i,
  output reg        tick_o
);

  reg [2:0] count_reg;

  // count input ticks, pulse when the code is reached
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= 3'h0;
      tick_o    <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (div_i == 3'h0) begin
        count_reg <= 3'h0;           // reserved code: hold
      end else if (tick_i) begin
        if (count_reg + 3'h1 >= div_i) begin
          count_reg <= 3'h0;
          tick_o    <= 1'b1;
        end else begin
          count_reg <= count_reg + 3'h1;
        end
      end
    end
  end

endmodule // mem_clk_divider

// ==== hw/memory_pll_config_status.v ====
// Purpose: memory clock configuration and status register with a
//          behavioural model of regulator and clock-generator start-up.
// Assumes: plain register port, read data one cycle after the strobe.
// Notes:   output clock is a tick stream (clock enable) for the memory side.
`timescale 1ns/100ps
`include "mem_clk_cfg_map.vh"
module memory_pll_config_status #(
  parameter LOCK_CYCLES = `LOCK_CYCLES,
  parameter VREG_CYCLES = `VREG_CYCLES
) (
  // clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_i,
  // register port
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  // memory clock side
  output reg         mem_clk_tick_o,
  output reg         mem_clk_ready_o,
  output reg         mem_clk_regulator_on_o,
  output reg         mem_clk_running_o
);

  // configuration fields
  reg        mem_clk_disable_reg;
  reg [2:0]  mem_clk_out_div_second_reg;
  reg [2:0]  mem_clk_out_div_first_reg;
  reg        mem_clk_regulator_disable_reg;
  reg [7:0]  mem_clk_mult_reg;
  reg [1:0]  internal_ref_voltage_ctrl_reg;
  reg [5:0]  mem_clk_input_div_reg;
  // status and delay counters
  reg        mem_clk_ready_reg;
  reg        mem_clk_regulator_ready_reg;
  reg [17:0] lock_count_reg;
  reg [17:0] vreg_count_reg;
  reg        diag_run_reg;
  reg [31:0] read_next;

  wire       div1_tick;
  wire       div2_tick;
  wire       cfg_wr = wr_i && (addr_i == `CFG_OFFSET);
  wire       pll_run = !mem_clk_disable_reg && mem_clk_regulator_ready_reg;

  // configuration writes; reserved bits 21..16 not stored
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mem_clk_disable_reg           <= 1'b1;
      mem_clk_out_div_second_reg    <= `RST_DIV;
      mem_clk_out_div_first_reg     <= `RST_DIV;
      mem_clk_regulator_disable_reg <= 1'b1;
      mem_clk_mult_reg              <= `RST_MULT;
      internal_ref_voltage_ctrl_reg <= `RST_VREF;
      mem_clk_input_div_reg         <= `RST_IDIV;
      diag_run_reg                  <= 1'b0;
    end else if (cfg_wr) begin
      mem_clk_disable_reg <= wdata_i[`F_PLL_DISABLE];
      mem_clk_out_div_second_reg <=
        wdata_i[`F_DIV2_HI:`F_DIV2_LO];
      mem_clk_out_div_first_reg <=
        wdata_i[`F_DIV1_HI:`F_DIV1_LO];
      mem_clk_regulator_disable_reg <= wdata_i[`F_REG_DISABLE];
      mem_clk_mult_reg              <= wdata_i[`F_MULT_HI:`F_MULT_LO];
      internal_ref_voltage_ctrl_reg <= wdata_i[`F_VREF_HI:`F_VREF_LO];
      mem_clk_input_div_reg         <= wdata_i[`F_IDIV_HI:`F_IDIV_LO];
    end else if (wr_i && addr_i == `CTRL_OFFSET) begin
      diag_run_reg <= wdata_i[0];
    end
  end

  // regulator settle delay; disable drops ready at once
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      vreg_count_reg              <= 18'h0;
      mem_clk_regulator_ready_reg <= 1'b0;
    end else if (mem_clk_regulator_disable_reg) begin
      vreg_count_reg              <= 18'h0;
      mem_clk_regulator_ready_reg <= 1'b0;
    end else if (vreg_count_reg >= VREG_CYCLES[17:0] - 18'h1) begin
      mem_clk_regulator_ready_reg <= 1'b1;
    end else begin
      vreg_count_reg <= vreg_count_reg + 18'h1;
    end
  end

  // lock delay; clock ready only after enable plus lock time
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      lock_count_reg    <= 18'h0;
      mem_clk_ready_reg <= 1'b0;
    end else if (!pll_run) begin
      // the clock generator also stops without a ready regulator
      lock_count_reg    <= 18'h0;
      mem_clk_ready_reg <= 1'b0;
    end else if (lock_count_reg >= LOCK_CYCLES[17:0] - 18'h1) begin
      mem_clk_ready_reg <= 1'b1;
    end else begin
      lock_count_reg <= lock_count_reg + 18'h1;
    end
  end

  // cascaded output dividers on the stable clock tick stream
  mem_clk_divider u_div_first (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .tick_i    (mem_clk_ready_reg),
    .div_i     (mem_clk_out_div_first_reg),
    .tick_o    (div1_tick)
  );

  mem_clk_divider u_div_second (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .tick_i    (div1_tick),
    .div_i     (mem_clk_out_div_second_reg),
    .tick_o    (div2_tick)
  );

  // read mux; unmapped addresses read zero
  always @* begin
    read_next = 32'h0;
    case (addr_i)
      `CFG_OFFSET: begin
        read_next[`F_PLL_READY]          = mem_clk_ready_reg;
        read_next[`F_PLL_DISABLE]        = mem_clk_disable_reg;
        read_next[`F_DIV2_HI:`F_DIV2_LO] = mem_clk_out_div_second_reg;
        read_next[`F_DIV1_HI:`F_DIV1_LO] = mem_clk_out_div_first_reg;
        read_next[`F_REG_READY] = mem_clk_regulator_ready_reg;
        read_next[`F_REG_DISABLE]        = mem_clk_regulator_disable_reg;
        read_next[`F_MULT_HI:`F_MULT_LO] = mem_clk_mult_reg;
        read_next[`F_VREF_HI:`F_VREF_LO] = internal_ref_voltage_ctrl_reg;
        read_next[`F_IDIV_HI:`F_IDIV_LO] = mem_clk_input_div_reg;
      end
      `CTRL_OFFSET: begin
        read_next[0] = diag_run_reg;
        read_next[1] = pll_run;
      end
      default: begin
        read_next = 32'h0;
      end
    endcase
  end

  // registered read data, output flops
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o                <= 32'h0;
      mem_clk_tick_o         <= 1'b0;
      mem_clk_ready_o        <= 1'b0;
      mem_clk_regulator_on_o <= 1'b0;
      mem_clk_running_o      <= 1'b0;
    end else begin
      rdata_o                <= rd_i ? read_next : 32'h0;
      mem_clk_tick_o         <= div2_tick;
      mem_clk_ready_o        <= mem_clk_ready_reg;
      mem_clk_regulator_on_o <= !mem_clk_regulator_disable_reg;
      mem_clk_running_o      <= pll_run;
    end
  end

endmodule // memory_pll_config_status

// ==== verif/mem_clk_cfg_props.sv ====
// Purpose: port assertions for the memory clock register block
// Assumes: one clock domain, reset active high
// Notes:   attached by the bind at the foot of this file
`timescale 1ns/100ps
module mem_clk_cfg_props #(
  parameter LOCK_CYCLES = 20
) (
  // clock and reset
  input wire        clk_sys_i,
  input wire        rst_i,
  // register port
  input wire [7:0]  addr_i,
  input wire [31:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [31:0] rdata_o,
  // memory clock side
  input wire        mem_clk_tick_o,
  input wire        mem_clk_ready_o,
  input wire        mem_clk_regulator_on_o,
  input wire        mem_clk_running_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // read data, reserved field and unmapped space
  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not idle");
  chk_reserved_zero: assert property (
    $past(rd_i) |-> rdata_o[21:16] == 6'h00)
    else $error("reserved field not zero");
  chk_unmapped_zero: assert property (
    $past(rd_i && addr_i == 8'h08) |-> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  // start-up ordering and disables
  chk_lock_delay: assert property (
    $rose(mem_clk_ready_o) |-> $past(mem_clk_running_o, LOCK_CYCLES))
    else $error("ready before lock delay");
  chk_reg_on_write: assert property (
    wr_i && addr_i == 8'h00 && !wdata_i[22]
    |-> ##[1:2] mem_clk_regulator_on_o)
    else $error("regulator not enabled");
  chk_reg_off_write: assert property (
    wr_i && addr_i == 8'h00 && wdata_i[22]
    |-> ##[1:2] !mem_clk_regulator_on_o)
    else $error("regulator not disabled");
  chk_dis_stops: assert property (
    wr_i && addr_i == 8'h00 && wdata_i[30]
    |-> ##[1:3] (!mem_clk_running_o && !mem_clk_ready_o))
    else $error("clock not stopped");
  chk_reg_before_run: assert property (
    $fell(mem_clk_regulator_on_o) |-> ##[0:2] !mem_clk_running_o)
    else $error("running without regulator");
  chk_tick_quiet: assert property (
    !mem_clk_ready_o [*5] |-> !mem_clk_tick_o)
    else $error("tick while not ready");
  // main scenarios
  cov_ready: cover property ($rose(mem_clk_ready_o));
  cov_tick: cover property (mem_clk_tick_o);
  cov_read: cover property (rd_i && addr_i == 8'h00);
endmodule // mem_clk_cfg_props
bind memory_pll_config_status mem_clk_cfg_props #(
  .LOCK_CYCLES(LOCK_CYCLES)
) props (.*);

// ==== verif/memory_pll_config_status_test.sv ====
// Purpose: self-checking bench for the memory clock register block
// Assumes: shortened lock and regulator counts
// Notes:   register port driven by non-blocking assignment on the edge
`timescale 1ns/100ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module memory_pll_config_status_test;
  localparam LOCK = 20;
  localparam VREG = 5;
  reg        clk_sys_i = 0;
  reg        rst_i = 1;
  reg [7:0]  addr_i = 8'h00;
  reg [31:0] wdata_i = 32'h0;
  reg        wr_i = 0;
  reg        rd_i = 0;
  wire [31:0] rdata_o;
  wire       mem_clk_tick_o, mem_clk_ready_o, mem_clk_regulator_on_o;
  wire       mem_clk_running_o;
  int        error_cnt = 0;
  int        checked = 0;
  memory_pll_config_status #(.LOCK_CYCLES(LOCK), .VREG_CYCLES(VREG)) dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .mem_clk_tick_o(mem_clk_tick_o), .mem_clk_ready_o(mem_clk_ready_o),
    .mem_clk_regulator_on_o(mem_clk_regulator_on_o),
    .mem_clk_running_o(mem_clk_running_o));
  // 50 MHz clock
  always #10 clk_sys_i = ~clk_sys_i;
  // configuration word with the low half left at its reset value
  function [31:0] cfg(input dis, input [2:0] d2, d1, input rdis);
    cfg = {1'b0, dis, d2, d1, 1'b0, rdis, 6'h00, 16'hFFFF};
  endfunction
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clk_sys_i); addr_i <= a; wdata_i <= d; wr_i <= 1;
    @(posedge clk_sys_i); wr_i <= 0;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    @(posedge clk_sys_i); addr_i <= a; rd_i <= 1;
    @(posedge clk_sys_i); rd_i <= 0;
    #1 `CHK("read word", e, rdata_o)
  endtask
  // cycles between two ticks, after letting a new setting settle
  task per(input int e);
    int n;
    int i;
    repeat (60) @(negedge clk_sys_i);
    i = 0;
    while (mem_clk_tick_o !== 1'b1 && i < 400) begin
      @(negedge clk_sys_i); i++; end
    n = 0;
    do begin @(negedge clk_sys_i); n++; end
      while (mem_clk_tick_o !== 1'b1 && n < 400);
    `CHK("tick period", e, n)
  endtask
  task end_of_test;
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    #400000;
    error_cnt++;
    end_of_test;
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 0;
    rd(8'h00, 32'h7F40FFFF);
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'h7F40FFFF);
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h08, 32'h0);
    wr(8'h00, cfg(1, 3'h1, 3'h2, 0));
    rd(8'h00, cfg(1, 3'h1, 3'h2, 0));
    repeat (VREG + 4) @(posedge clk_sys_i);
    rd(8'h00, cfg(1, 3'h1, 3'h2, 0) | 32'h00800000);
    wr(8'h00, cfg(0, 3'h1, 3'h2, 0));
    rd(8'h00, cfg(0, 3'h1, 3'h2, 0) | 32'h00800000);
    repeat (LOCK + 6) @(posedge clk_sys_i);
    rd(8'h00, cfg(0, 3'h1, 3'h2, 0) | 32'h80800000);
    // control word: scratch flag and running status
    wr(8'h04, 32'h1);
    rd(8'h04, 32'h3);
    `CHK("regulator on", 1'b1, mem_clk_regulator_on_o)
    `CHK("running", 1'b1, mem_clk_running_o)
    `CHK("ready out", 1'b1, mem_clk_ready_o)
    for (int d = 1; d < 8; d++) begin
      wr(8'h00, cfg(0, 3'h1, d[2:0], 0));
      per(d);
      if (d < 7) begin
        wr(8'h00, cfg(0, d[2:0], 3'h7, 0));
        per(7 * d);
      end
    end
    wr(8'h00, cfg(0, 3'h1, 3'h0, 0));
    repeat (60) @(negedge clk_sys_i);
    `CHK("tick halted", 1'b0, mem_clk_tick_o)
    wr(8'h00, cfg(1, 3'h1, 3'h1, 0));
    rd(8'h00, cfg(1, 3'h1, 3'h1, 0) | 32'h00800000);
    `CHK("ready level", 1'b0, mem_clk_ready_o)
    `CHK("stopped", 1'b0, mem_clk_running_o)
    wr(8'h00, cfg(1, 3'h1, 3'h1, 1));
    rd(8'h00, cfg(1, 3'h1, 3'h1, 1));
    end_of_test;
  end
endmodule // memory_pll_config_status_test
